// ---- rtl/vcm_pkg.sv ----
// Shared constants for the voice channel mux and monitoring block.
package vcm_pkg;
    // Sample and gain widths.
    localparam int VCM_SAMPLE_W = 16;
    localparam int VCM_GAIN_W = 6;
    // Data format field codes.
    localparam logic [1:0] VCM_FMT_ALAW = 2'h0;
    localparam logic [1:0] VCM_FMT_MULAW = 2'h1;
    localparam logic [1:0] VCM_FMT_LIN8 = 2'h2;
    localparam logic [1:0] VCM_FMT_LIN16 = 2'h3;
    // Transmit channel source codes.
    localparam logic [1:0] VCM_TXSRC_CODEC = 2'h0;
    localparam logic [1:0] VCM_TXSRC_SUM = 2'h1;
    localparam logic [1:0] VCM_TXSRC_OPP = 2'h2;
    localparam logic [1:0] VCM_TXSRC_IDLE = 2'h3;
    // Codec receive source codes.
    localparam logic [1:0] VCM_RXSRC_ONE = 2'h0;
    localparam logic [1:0] VCM_RXSRC_TWO = 2'h1;
    localparam logic [1:0] VCM_RXSRC_SUM = 2'h2;
    localparam logic [1:0] VCM_RXSRC_IDLE = 2'h3;
    // Idle codes per format.
    localparam logic [7:0] VCM_IDLE_ALAW = 8'h55;
    localparam logic [7:0] VCM_IDLE_MULAW = 8'hFF;
    localparam logic [15:0] VCM_IDLE_LIN = 16'h0000;
    // Gains are attenuation codes in half-decibel steps (code 0 is 0 dB).
    localparam logic [5:0] VCM_GAIN_0DB = 6'h00;
    localparam logic [5:0] VCM_LSPK_MON_LOW = 6'h13;
    localparam logic [5:0] VCM_LSPK_MON_HIGH = 6'h2B;
    // Reset values and FIFO depth.
    localparam logic [15:0] VCM_RST_SAMPLE = 16'h0000;
    localparam int VCM_FIFO_DEPTH = 16;
endpackage

// ---- rtl/vcm_stream_if.sv ----
// Valid/ready sample stream between the block's own modules.
`timescale 1ns/100ps
interface vcm_stream_if #(parameter int WIDTH = 16);
    logic [WIDTH-1:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface

// ---- rtl/vcm_fifo.sv ----
// Synchronous FIFO with valid/ready on both sides.
`timescale 1ns/100ps
module vcm_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk, // System clock.
    input wire logic rst_n, // Asynchronous reset, active low.
    vcm_stream_if.snk wr, // Filling side.
    vcm_stream_if.src rd // Draining side.
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
            $error("vcm_fifo: DEPTH must be a power of two, at least 2");
        end
    end
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wp_q, wp_d, rp_q, rp_d;
    logic push, pop;
    // Full and empty come straight from the pointers, one spare bit apart.
    always_comb begin
        wr.ready = (wp_q[AW] == rp_q[AW]) || (wp_q[AW-1:0] != rp_q[AW-1:0]);
        rd.valid = (wp_q != rp_q);
        rd.data = mem_q[rp_q[AW-1:0]];
        push = wr.valid && wr.ready;
        pop = rd.valid && rd.ready;
        wp_d = push ? wp_q + 1'b1 : wp_q;
        rp_d = pop ? rp_q + 1'b1 : rp_q;
    end
    // Pointers reset; storage needs no reset since empty hides it.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_q[wp_q[AW-1:0]] <= wr.data;
        end
    end
endmodule

// ---- rtl/vcm_chan_codec.sv ----
// Per-channel format conversion and masking, receive and transmit.
`timescale 1ns/100ps
module vcm_chan_codec
    import vcm_pkg::*;
(
    input wire logic [15:0] rx_word, // Received channel word.
    input wire logic [1:0] rx_format, // Receive format field.
    input wire logic [1:0] linear8_select, // Bit0 transmit, bit1 receive.
    input wire logic [7:0] mask_value, // Channel mask.
    input wire logic [15:0] tx_linear, // Linear sample to send.
    input wire logic tx_idle, // Send the idle code instead.
    output logic [15:0] rx_linear, // Decoded linear receive sample.
    output logic [15:0] tx_word // Encoded transmit word.
);
    logic [1:0] rx_fmt, tx_fmt;
    logic [7:0] rx_byte, tx_byte;

    function automatic logic [7:0] law_enc(input logic [15:0] s,
                                           input logic mu);
        logic neg;
        logic [16:0] mag;
        logic [13:0] m;
        logic [2:0] seg;
        logic [3:0] mant;
        neg = s[15];
        mag = neg ? 17'h10000 - {1'b0, s} : {1'b0, s};
        seg = 3'h0;
        if (mu) begin
            m = (mag[15:2] > 14'h1FDE) ? 14'h1FFF : mag[15:2] + 14'h0021;
            for (int k = 1; k < 8; k++) begin
                if (m >= (14'h0020 << k)) seg = 3'(k);
            end
            // Widened shift so the top segment does not wrap to no shift.
            mant = 4'(m >> ({1'b0, seg} + 4'h1));
            law_enc = ~{neg, seg, mant};
        end else begin
            m = (mag > 17'h0FFFF) ? 14'h0FFF : {2'h0, mag[15:4]};
            for (int k = 1; k < 8; k++) begin
                if (m >= (14'h0010 << k)) seg = 3'(k);
            end
            mant = (seg == 3'h0) ? 4'(m >> 1) : 4'(m >> seg);
            law_enc = {~neg, seg, mant} ^ 8'h55;
        end
    endfunction

    function automatic logic [15:0] law_dec(input logic [7:0] c,
                                            input logic mu);
        logic [7:0] v;
        logic [15:0] mag;
        logic neg;
        v = mu ? ~c : c ^ 8'h55;
        if (mu) begin
            neg = v[7];
            mag = 16'(((({12'h0, v[3:0]} << 1) + 16'h0021) << v[6:4])
                      - 16'h0021) << 2;
        end else begin
            neg = !v[7];
            if (v[6:4] == 3'h0) begin
                mag = ({12'h0, v[3:0]} << 1) + 16'h0001;
            end else begin
                mag = 16'((({12'h0, v[3:0]} << 1) + 16'h0021)
                          << (v[6:4] - 3'h1));
            end
            mag = mag << 4;
        end
        law_dec = neg ? 16'h0000 - mag : mag;
    endfunction

    // The 8-bit linear selects override the field per direction.
    always_comb begin
        rx_fmt = linear8_select[1] ? VCM_FMT_LIN8 : rx_format;
        tx_fmt = linear8_select[0] ? VCM_FMT_LIN8 : rx_format;
        // Receive: mask the raw byte, then expand it.
        rx_byte = rx_word[7:0] ^ mask_value;
        unique case (rx_fmt)
            VCM_FMT_ALAW: rx_linear = law_dec(rx_byte, 1'b0);
            VCM_FMT_MULAW: rx_linear = law_dec(rx_byte, 1'b1);
            VCM_FMT_LIN8: rx_linear = {rx_byte, 8'h00};
            VCM_FMT_LIN16: rx_linear = rx_word;
        endcase
        // Transmit: compress, then mask; idle codes are sent unmasked.
        unique case (tx_fmt)
            VCM_FMT_ALAW: tx_byte = tx_idle ? VCM_IDLE_ALAW
                                            : law_enc(tx_linear, 1'b0);
            VCM_FMT_MULAW: tx_byte = tx_idle ? VCM_IDLE_MULAW
                                             : law_enc(tx_linear, 1'b1);
            VCM_FMT_LIN8: tx_byte = tx_idle ? VCM_IDLE_LIN[15:8]
                                            : tx_linear[15:8];
            VCM_FMT_LIN16: tx_byte = 8'h00;
        endcase
        if (tx_fmt == VCM_FMT_LIN16) begin
            tx_word = tx_idle ? VCM_IDLE_LIN : tx_linear;
        end else if (tx_idle) begin
            tx_word = {8'h00, tx_byte};
        end else begin
            tx_word = {8'h00, tx_byte ^ mask_value};
        end
    end
endmodule

// ---- rtl/vcm_top.sv ----
// Voice channel source selection, formats and controlled monitoring.
`timescale 1ns/100ps
// Functional notes
// - Controlled monitoring acts only while speakerphone mode is also on.
// - Controlled monitoring pins the receive attenuation stage at 0 dB.
// - In transmit mode the loudspeaker drops to -9.5 or -21.5 dB.
// - Handset keeps its normal receive; transmit acts as in speakerphone.
// - Loudspeaker setting already at or below -9.5 dB is left alone.
// - Sidetone tap select set moves the tap after the attenuation stage.
// - Transmit source: codec, codec plus opposite receive, opposite, idle.
// - Codec receive source: channel one, channel two, both summed, idle.
// - A disabled transmit channel is not driven.
// - Receive format field picks A-law, mu-law, 8-bit or 16-bit linear.
// - 8-bit linear may be chosen separately for transmit and receive.
// - 8-bit formats are masked in both directions by the channel mask, transmit idle codes excepted.
module vcm_top
    import vcm_pkg::*;
#(
    parameter int FIFO_DEPTH = VCM_FIFO_DEPTH
) (
    input wire logic sys_clk, // System clock, 125 MHz.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic frame_tick, // One pulse per voice frame.
    input wire logic controlled_monitor_enable, // Monitoring mode request.
    input wire logic speakerphone_enable, // Speakerphone mode on.
    input wire logic monitor_attenuation_select, // 0: -9.5 dB, 1: -21.5 dB.
    input wire logic atten_tx_mode, // Attenuation control in transmit.
    input wire logic [5:0] atten_ctrl_gain, // Receive gain from control.
    input wire logic [5:0] loudspeaker_gain_setting, // Programmed level.
    input wire logic sidetone_tap_select, // 1: tap after attenuation.
    input wire logic [1:0] tx_chan_one_source, // Channel one source.
    input wire logic [1:0] tx_chan_two_source, // Channel two source.
    input wire logic [1:0] rx_source_select, // Codec receive source.
    input wire logic tx_chan_one_enable, // Channel one transmit on.
    input wire logic tx_chan_two_enable, // Channel two transmit on.
    input wire logic [3:0] rx_chan_one_atten, // 6 dB steps.
    input wire logic [3:0] rx_chan_two_atten, // 6 dB steps.
    input wire logic [1:0] rx_chan_one_format, // Channel one format.
    input wire logic [1:0] rx_chan_two_format, // Channel two format.
    input wire logic [1:0] chan_one_linear8_select, // Bit0 tx, bit1 rx.
    input wire logic [1:0] chan_two_linear8_select, // Bit0 tx, bit1 rx.
    input wire logic [7:0] chan_one_mask_value, // Channel one mask.
    input wire logic [7:0] chan_two_mask_value, // Channel two mask.
    input wire logic [15:0] rx_chan_one, // Channel one receive word.
    input wire logic [15:0] rx_chan_two, // Channel two receive word.
    input wire logic [15:0] codec_tx_samples, // Linear codec transmit.
    input wire logic codec_rx_ready, // Codec path takes a sample.
    output logic [15:0] codec_rx_samples, // Linear codec receive.
    output logic codec_rx_valid, // Codec receive sample waiting.
    output logic rx_accept_ready, // Low when the receive FIFO is full.
    output logic [15:0] tx_chan_one, // Channel one transmit word.
    output logic [15:0] tx_chan_two, // Channel two transmit word.
    output logic tx_chan_one_oe_n, // Low while channel one is driven.
    output logic tx_chan_two_oe_n, // Low while channel two is driven.
    output logic [5:0] receive_attenuation_stage, // Receive stage gain.
    output logic [5:0] loudspeaker_amplifier, // Loudspeaker gain.
    output logic handset_rx_normal, // Handset gets plain receive signal.
    output logic tx_speakerphone_path, // Transmit uses speakerphone path.
    output logic sidetone_tap_after // Sidetone tapped after attenuation.
);
    initial begin
        if (FIFO_DEPTH < 2) begin
            $error("vcm_top: FIFO_DEPTH must be at least 2");
        end
    end

    vcm_stream_if #(.WIDTH(VCM_SAMPLE_W)) push_if ();
    vcm_stream_if #(.WIDTH(VCM_SAMPLE_W)) pop_if ();

    logic monitor_active;
    logic [5:0] rxg_d, rxg_q, lsg_d, lsg_q;
    logic hs_d, hs_q, txsp_d, txsp_q, st_d, st_q;
    logic [15:0] rx1_lin, rx2_lin, rx1_sc, rx2_sc;
    logic [15:0] sum_rx, tx1_lin, tx2_lin, tx1_word, tx2_word, rx_pick;
    logic tx1_idle, tx2_idle;
    logic [15:0] tx1_d, tx1_q, tx2_d, tx2_q;
    logic oe1_d, oe1_q, oe2_d, oe2_q;
    logic [15:0] push_d, push_q;
    logic pend_d, pend_q;

    // Saturating sum keeps a conference from wrapping on loud talkers.
    function automatic logic [15:0] sat_add(input logic [15:0] a,
                                            input logic [15:0] b);
        logic [16:0] s;
        s = {a[15], a} + {b[15], b};
        if (s[16] != s[15]) begin
            sat_add = s[16] ? 16'h8000 : 16'h7FFF;
        end else begin
            sat_add = s[15:0];
        end
    endfunction

    // Monitoring only counts while speakerphone mode is on as well.
    assign monitor_active = controlled_monitor_enable
                            && speakerphone_enable;

    // Gain and path controls, recomputed every cycle.
    always_comb begin
        rxg_d = monitor_active ? VCM_GAIN_0DB : atten_ctrl_gain;
        lsg_d = loudspeaker_gain_setting;
        // A setting already quiet enough is kept as it is.
        if (monitor_active && atten_tx_mode
            && loudspeaker_gain_setting < VCM_LSPK_MON_LOW) begin
            lsg_d = monitor_attenuation_select ? VCM_LSPK_MON_HIGH
                                               : VCM_LSPK_MON_LOW;
        end
        hs_d = !speakerphone_enable || monitor_active;
        txsp_d = speakerphone_enable;
        st_d = sidetone_tap_select;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxg_q <= VCM_GAIN_0DB;
            lsg_q <= VCM_GAIN_0DB;
            hs_q <= 1'b1;
            txsp_q <= 1'b0;
            st_q <= 1'b0;
        end else begin
            rxg_q <= rxg_d;
            lsg_q <= lsg_d;
            hs_q <= hs_d;
            txsp_q <= txsp_d;
            st_q <= st_d;
        end
    end

    assign receive_attenuation_stage = rxg_q;
    assign loudspeaker_amplifier = lsg_q;
    assign handset_rx_normal = hs_q;
    assign tx_speakerphone_path = txsp_q;
    assign sidetone_tap_after = st_q;

    // Channel format conversion and masking.
    vcm_chan_codec u_codec_one (
        .rx_word(rx_chan_one),
        .rx_format(rx_chan_one_format),
        .linear8_select(chan_one_linear8_select),
        .mask_value(chan_one_mask_value),
        .tx_linear(tx1_lin),
        .tx_idle(tx1_idle),
        .rx_linear(rx1_lin),
        .tx_word(tx1_word)
    );

    vcm_chan_codec u_codec_two (
        .rx_word(rx_chan_two),
        .rx_format(rx_chan_two_format),
        .linear8_select(chan_two_linear8_select),
        .mask_value(chan_two_mask_value),
        .tx_linear(tx2_lin),
        .tx_idle(tx2_idle),
        .rx_linear(rx2_lin),
        .tx_word(tx2_word)
    );

    // Source selection; each receive channel is scaled before any sum.
    always_comb begin
        rx1_sc = $signed(rx1_lin) >>> rx_chan_one_atten;
        rx2_sc = $signed(rx2_lin) >>> rx_chan_two_atten;
        sum_rx = sat_add(rx1_sc, rx2_sc);
        tx1_idle = (tx_chan_one_source == VCM_TXSRC_IDLE);
        tx2_idle = (tx_chan_two_source == VCM_TXSRC_IDLE);
        unique case (tx_chan_one_source)
            VCM_TXSRC_CODEC: tx1_lin = codec_tx_samples;
            VCM_TXSRC_SUM: tx1_lin = sat_add(codec_tx_samples, rx2_sc);
            VCM_TXSRC_OPP: tx1_lin = rx2_sc;
            VCM_TXSRC_IDLE: tx1_lin = VCM_IDLE_LIN;
        endcase
        unique case (tx_chan_two_source)
            VCM_TXSRC_CODEC: tx2_lin = codec_tx_samples;
            VCM_TXSRC_SUM: tx2_lin = sat_add(codec_tx_samples, rx1_sc);
            VCM_TXSRC_OPP: tx2_lin = rx1_sc;
            VCM_TXSRC_IDLE: tx2_lin = VCM_IDLE_LIN;
        endcase
        unique case (rx_source_select)
            VCM_RXSRC_ONE: rx_pick = rx1_sc;
            VCM_RXSRC_TWO: rx_pick = rx2_sc;
            VCM_RXSRC_SUM: rx_pick = sum_rx;
            VCM_RXSRC_IDLE: rx_pick = VCM_IDLE_LIN;
        endcase
    end

    // Frame-rate registers; a disabled channel releases its lines.
    always_comb begin
        tx1_d = tx1_q;
        tx2_d = tx2_q;
        oe1_d = oe1_q;
        oe2_d = oe2_q;
        push_d = push_q;
        pend_d = pend_q && !push_if.ready;
        if (frame_tick) begin
            oe1_d = !tx_chan_one_enable;
            oe2_d = !tx_chan_two_enable;
            tx1_d = tx_chan_one_enable ? tx1_word : VCM_RST_SAMPLE;
            tx2_d = tx_chan_two_enable ? tx2_word : VCM_RST_SAMPLE;
            // A sample offered to a full FIFO is replaced by the newer one.
            push_d = rx_pick;
            pend_d = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx1_q <= VCM_RST_SAMPLE;
            tx2_q <= VCM_RST_SAMPLE;
            oe1_q <= 1'b1;
            oe2_q <= 1'b1;
            push_q <= VCM_RST_SAMPLE;
            pend_q <= 1'b0;
        end else begin
            tx1_q <= tx1_d;
            tx2_q <= tx2_d;
            oe1_q <= oe1_d;
            oe2_q <= oe2_d;
            push_q <= push_d;
            pend_q <= pend_d;
        end
    end

    assign tx_chan_one = tx1_q;
    assign tx_chan_two = tx2_q;
    assign tx_chan_one_oe_n = oe1_q;
    assign tx_chan_two_oe_n = oe2_q;

    // Receive samples queue toward the codec so it may stall briefly.
    assign push_if.data = push_q;
    assign push_if.valid = pend_q;
    assign rx_accept_ready = push_if.ready;
    assign pop_if.ready = codec_rx_ready;
    assign codec_rx_samples = pop_if.data;
    assign codec_rx_valid = pop_if.valid;

    vcm_fifo #(.WIDTH(VCM_SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .wr(push_if),
        .rd(pop_if)
    );

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_tx_quiet_frame;
        controlled_monitor_enable && !speakerphone_enable
            && atten_tx_mode;
    endsequence
    sequence s_mon_tx_frame;
        monitor_active && atten_tx_mode
            && loudspeaker_gain_setting < VCM_LSPK_MON_LOW;
    endsequence
    sequence s_one_off;
        frame_tick && !tx_chan_one_enable;
    endsequence

    property p_mon_needs_sp;
        s_tx_quiet_frame |=> loudspeaker_amplifier
            == $past(loudspeaker_gain_setting);
    endproperty
    a_mon_needs_sp: assert property (p_mon_needs_sp)
        else $error("Monitoring acted without speakerphone mode.");

    property p_rx_stage_zero;
        monitor_active |=> receive_attenuation_stage == VCM_GAIN_0DB;
    endproperty
    a_rx_stage_zero: assert property (p_rx_stage_zero)
        else $error("Receive stage not held at 0 dB while monitoring.");

    property p_mon_gain;
        s_mon_tx_frame |=> loudspeaker_amplifier == ($past(
            monitor_attenuation_select) ? VCM_LSPK_MON_HIGH
                                        : VCM_LSPK_MON_LOW);
    endproperty
    a_mon_gain: assert property (p_mon_gain)
        else $error("Loudspeaker monitoring gain is wrong.");

    property p_handset;
        monitor_active |=> handset_rx_normal && tx_speakerphone_path;
    endproperty
    a_handset: assert property (p_handset)
        else $error("Monitoring paths are wrong.");

    property p_quiet_kept;
        loudspeaker_gain_setting >= VCM_LSPK_MON_LOW |=>
            loudspeaker_amplifier == $past(loudspeaker_gain_setting);
    endproperty
    a_quiet_kept: assert property (p_quiet_kept)
        else $error("Quiet loudspeaker setting was attenuated further.");

    property p_sidetone;
        sidetone_tap_select |=> sidetone_tap_after;
    endproperty
    a_sidetone: assert property (p_sidetone)
        else $error("Sidetone tap did not move after attenuation.");

    property p_tx_passthru;
        frame_tick && tx_chan_one_enable
            && tx_chan_one_source == VCM_TXSRC_CODEC
            && rx_chan_one_format == VCM_FMT_LIN16
            && !chan_one_linear8_select[0]
            |=> tx_chan_one == $past(codec_tx_samples);
    endproperty
    a_tx_passthru: assert property (p_tx_passthru)
        else $error("Channel one did not carry codec samples.");

    property p_tx_off;
        s_one_off |=> tx_chan_one_oe_n && tx_chan_one == VCM_RST_SAMPLE;
    endproperty
    a_tx_off: assert property (p_tx_off)
        else $error("Disabled channel one is still driven.");

    property p_tx_on;
        frame_tick && tx_chan_one_enable |=> !tx_chan_one_oe_n;
    endproperty
    a_tx_on: assert property (p_tx_on)
        else $error("Enabled channel one is not driven.");
endmodule

// ---- testbench/vcm_bus_model.sv ----
// Far-side slot handler model feeding the receive channel words.
`timescale 1ns/100ps
module vcm_bus_model (
    input wire logic sys_clk, // Clock.
    input wire logic rst_n, // Reset, active low.
    input wire logic go, // Request one frame.
    input wire logic [15:0] word_one, // Next channel one word.
    input wire logic [15:0] word_two, // Next channel two word.
    output logic frame_tick, // Frame pulse.
    output logic [15:0] rx_chan_one, // Slot one.
    output logic [15:0] rx_chan_two // Slot two.
);
    // Slots hold data in the tick cycle, then invert on every later cycle, so a
    // sample one cycle late shows wrong data instead of silently reusing old data.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_tick <= 1'b0;
            rx_chan_one <= 16'h0000;
            rx_chan_two <= 16'h0000;
        end else begin
            frame_tick <= go;
            rx_chan_one <= go ? word_one : ~rx_chan_one;
            rx_chan_two <= go ? word_two : ~rx_chan_two;
        end
    end
endmodule

// ---- testbench/test_vcm_top.sv ----
// Self-checking bench for the voice channel mux and monitoring block.
`timescale 1ns/100ps
module test_vcm_top;
    import vcm_pkg::*;
    logic sys_clk = 0, rst_n = 0, go = 0, codec_rx_ready = 0;
    logic controlled_monitor_enable = 0, speakerphone_enable = 0;
    logic monitor_attenuation_select = 0, atten_tx_mode = 0;
    logic sidetone_tap_select = 0;
    logic tx_chan_one_enable = 1, tx_chan_two_enable = 1;
    logic [5:0] atten_ctrl_gain = 6'h05, loudspeaker_gain_setting = 6'h00;
    logic [1:0] tx_chan_one_source = 2'h0, tx_chan_two_source = 2'h0;
    logic [1:0] rx_source_select = 2'h0, chan_one_linear8_select = 2'h0;
    logic [1:0] chan_two_linear8_select = 2'h0;
    logic [1:0] rx_chan_one_format = 2'h3, rx_chan_two_format = 2'h3;
    logic [3:0] rx_chan_one_atten = 4'h0, rx_chan_two_atten = 4'h0;
    logic [7:0] chan_one_mask_value = 8'h0F, chan_two_mask_value = 8'h00;
    logic [15:0] word_one = 16'h0100, word_two = 16'h0040;
    logic [15:0] codec_tx_samples = 16'h0123;
    logic [15:0] rx_chan_one, rx_chan_two, codec_rx_samples;
    logic [15:0] tx_chan_one, tx_chan_two;
    logic frame_tick, codec_rx_valid, rx_accept_ready, tx_chan_one_oe_n;
    logic tx_chan_two_oe_n, handset_rx_normal, tx_speakerphone_path;
    logic sidetone_tap_after;
    logic [5:0] receive_attenuation_stage, loudspeaker_amplifier;
    logic [15:0] rx_exp [4] = '{16'h0100, 16'h0040, 16'h0140, 16'h0000};
    int n_fail = 0, checks = 0, n;

    vcm_top vcm_top_i (.*);
    vcm_bus_model vcm_bus_model_i (.*);

    // Clock of 8 ns period.
    always #4 sys_clk = ~sys_clk;

    task chk(input string what, input logic [15:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Inputs move 1 ns after the edge to stay clear of the design's flops.
    task step(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask

    task frame;
        go = 1;
        step(1);
        go = 0;
        step(2);
    endtask

    task mon(input logic c, s, m, t, input logic [5:0] l, ras, lsa);
        controlled_monitor_enable = c;
        speakerphone_enable = s;
        monitor_attenuation_select = m;
        atten_tx_mode = t;
        loudspeaker_gain_setting = l;
        sidetone_tap_select = m;
        step(2);
        chk("stage", 16'(receive_attenuation_stage), 16'(ras));
        chk("speaker", 16'(loudspeaker_amplifier), 16'(lsa));
        chk("handset", 16'(handset_rx_normal), 16'(!s || c));
        chk("tx_path", 16'(tx_speakerphone_path), 16'(s));
        chk("tap", 16'(sidetone_tap_after), 16'(m));
    endtask

    task rx_take(input logic [15:0] exp);
        frame;
        chk("rx_valid", 16'(codec_rx_valid), 16'h0001);
        chk("rx_sample", codec_rx_samples, exp);
        codec_rx_ready = 1;
        step(1);
        codec_rx_ready = 0;
    endtask

    // Pops are counted where valid has settled, ahead of the popping edge.
    task drain;
        n = 0;
        codec_rx_ready = 1;
        repeat (40) begin
            if (codec_rx_valid === 1'b1) n++;
            step(1);
        end
        codec_rx_ready = 0;
    endtask

    task end_sim;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Main sequence.
    initial begin
        step(3);
        chk("oe_n reset", 16'(tx_chan_one_oe_n), 16'h0001);
        chk("stage reset", 16'(receive_attenuation_stage), 16'h0000);
        step(3);
        rst_n = 1;
        mon(1, 0, 0, 1, 6'h00, 6'h05, 6'h00);
        mon(1, 1, 0, 0, 6'h00, 6'h00, 6'h00);
        mon(1, 1, 0, 1, 6'h00, 6'h00, 6'h13);
        mon(1, 1, 1, 1, 6'h0A, 6'h00, 6'h2B);
        mon(1, 1, 0, 1, 6'h13, 6'h00, 6'h13);
        mon(1, 1, 1, 1, 6'h20, 6'h00, 6'h20);
        mon(0, 1, 0, 1, 6'h00, 6'h05, 6'h00);
        $display("test monitoring done");
        tx_chan_two_source = VCM_TXSRC_OPP;
        frame;
        chk("tx1 codec", tx_chan_one, 16'h0123);
        chk("tx2 opp", tx_chan_two, 16'h0100);
        chk("oe1", 16'(tx_chan_one_oe_n), 16'h0000);
        tx_chan_one_source = VCM_TXSRC_SUM;
        tx_chan_two_source = VCM_TXSRC_IDLE;
        frame;
        chk("tx1 sum", tx_chan_one, 16'h0163);
        chk("tx2 idle", tx_chan_two, 16'h0000);
        tx_chan_one_enable = 0;
        tx_chan_two_enable = 0;
        tx_chan_two_source = VCM_TXSRC_OPP;
        rx_chan_one_atten = 4'h1;
        frame;
        chk("oe1 off", 16'(tx_chan_one_oe_n), 16'h0001);
        chk("tx1 off", tx_chan_one, 16'h0000);
        chk("oe2 off", 16'(tx_chan_two_oe_n), 16'h0001);
        chk("tx2 off", tx_chan_two, 16'h0000);
        tx_chan_one_enable = 1;
        tx_chan_two_enable = 1;
        frame;
        chk("tx2 atten", tx_chan_two, 16'h0080);
        rx_chan_one_atten = 4'h0;
        tx_chan_one_source = VCM_TXSRC_CODEC;
        rx_chan_one_format = VCM_FMT_LIN8;
        codec_tx_samples = 16'h5A00;
        frame;
        chk("tx1 mask", tx_chan_one, 16'h0055);
        rx_chan_one_format = VCM_FMT_LIN16;
        chan_one_linear8_select = 2'h1;
        frame;
        chk("tx1 lin8", tx_chan_one, 16'h0055);
        chan_one_linear8_select = 2'h0;
        tx_chan_one_source = VCM_TXSRC_IDLE;
        rx_chan_one_format = VCM_FMT_ALAW;
        frame;
        chk("idle a", tx_chan_one, {8'h00, VCM_IDLE_ALAW});
        rx_chan_one_format = VCM_FMT_MULAW;
        frame;
        chk("idle mu", tx_chan_one, {8'h00, VCM_IDLE_MULAW});
        $display("test transmit done");
        rx_chan_one_format = VCM_FMT_LIN16;
        drain;
        for (int i = 0; i < 4; i++) begin
            rx_source_select = 2'(i);
            rx_take(rx_exp[i]);
        end
        // Receive-only 8-bit linear: byte 00 masked by 0F lands on top.
        rx_source_select = VCM_RXSRC_ONE;
        chan_one_linear8_select = 2'h2;
        rx_take(16'h0F00);
        chan_one_linear8_select = 2'h0;
        $display("test receive done");
        repeat (18) frame;
        chk("fifo full", 16'(rx_accept_ready), 16'h0000);
        drain;
        chk("fifo count", 16'(n), 16'h0011);
        $display("test fifo done");
        end_sim;
    end

    // Whole run needs well under 1000 cycles; this cuts a hang short.
    initial begin
        #20000;
        n_fail++;
        end_sim;
    end
endmodule
